/* common/adctwc_defs.vh */
// register indexes, field positions, reset values and timing constants
// of the converter timing and window control block.
// assumes: included by bare name from the design files.
`ifndef ADCTWC_DEFS_VH
`define ADCTWC_DEFS_VH

// register indexes (byte address = 4 * index)
`define ADCTWC_IDX_CTRL      6'h00
`define ADCTWC_IDX_CLKREF    6'h02
`define ADCTWC_IDX_DELAY     6'h03
`define ADCTWC_IDX_WINMODE   6'h04
`define ADCTWC_IDX_SAMPLING_EXTENSION   6'h05
`define ADCTWC_IDX_INSEL     6'h06
`define ADCTWC_IDX_COMMAND   6'h08
`define ADCTWC_IDX_IRQMASK   6'h0a
`define ADCTWC_IDX_IRQSTAT   6'h0b
`define ADCTWC_IDX_RESULT    6'h10
`define ADCTWC_IDX_WINLOW    6'h12
`define ADCTWC_IDX_WINHIGH   6'h14

// reset values
`define ADCTWC_RST_BYTE      8'h00
`define ADCTWC_RST_WORD      16'h0000
`define ADCTWC_RST_FLAGS     2'h0
`define ADCTWC_RST_MODE      3'h0
`define ADCTWC_RST_FIELD     5'h00

// field positions
`define ADCTWC_CTRL_ENABLE   0
`define ADCTWC_CR_SAMPLE_CAP_SELECT    6
`define ADCTWC_CR_REF_HI     5
`define ADCTWC_CR_REF_LO     4
`define ADCTWC_CR_DIV_HI     2
`define ADCTWC_DL_INIT_HI    7
`define ADCTWC_DL_INIT_LO    5
`define ADCTWC_DL_AUTOVAR    4
`define ADCTWC_DL_GAP_HI     3
`define ADCTWC_WM_HI         2
`define ADCTWC_SL_HI         4
`define ADCTWC_IS_HI         4
`define ADCTWC_CMD_START     0
`define ADCTWC_IRQ_READY     0
`define ADCTWC_IRQ_WINDOW    1

// reference choice codes
`define ADCTWC_REF_INTERNAL  2'h0
`define ADCTWC_REF_SUPPLY    2'h1
`define ADCTWC_REF_EXTERNAL  2'h2
`define ADCTWC_REF_RESERVED  2'h3

// window modes
`define ADCTWC_WIN_NONE      3'h0
`define ADCTWC_WIN_BELOW     3'h1
`define ADCTWC_WIN_ABOVE     3'h2
`define ADCTWC_WIN_INSIDE    3'h3
`define ADCTWC_WIN_OUTSIDE   3'h4

// positive input choices
`define ADCTWC_IN_PIN_LAST   5'h0f
`define ADCTWC_IN_DACREF     5'h1c
`define ADCTWC_IN_TEMP       5'h1e
`define ADCTWC_IN_GROUND     5'h1f

// timing, in converter clock cycles; the divider base is in I_CLK cycles
`define ADCTWC_SAMPLE_BASE   9'h002
`define ADCTWC_DIV_BASE      9'h002
`define ADCTWC_ONE           9'h001
`define ADCTWC_ZERO9         9'h000

// start-up delay lengths, in converter clock cycles
`define ADCTWC_INIT_0        9'h000
`define ADCTWC_INIT_16       9'h010
`define ADCTWC_INIT_32       9'h020
`define ADCTWC_INIT_64       9'h040
`define ADCTWC_INIT_128      9'h080
`define ADCTWC_INIT_256      9'h100

`endif

/* hw/adctwc_top.v */
// converter timing and window control: clock divider, reference and
// capacitor selects, start-up delay, sample gap, sampling length,
// deferred input select and window compare, behind an APB slave.
// assumes: analog core runs one sample per O_CORE_CONVERT level and
// answers with I_CORE_DONE; all inputs synchronous to I_CLK.
//
// The APB register port was chosen for this implementation.
`include "adctwc_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module adctwc_top (
	input  wire        I_CLK,
	input  wire        I_ARST_N,
	input  wire        I_PSEL,
	input  wire        I_PENABLE,
	input  wire        I_PWRITE,
	input  wire [7:0]  I_PADDR,
	input  wire [31:0] I_PWDATA,
	output reg  [31:0] O_PRDATA,
	output reg         O_PREADY,
	output reg         O_PSLVERR,
	input  wire        I_DEEP_WAKE,
	input  wire        I_CORE_DONE,
	input  wire        I_CORE_LAST,
	input  wire [15:0] I_CORE_RESULT,
	output reg         O_CORE_CONVERT,
	output reg         O_SAMPLE_CLOSE,
	output reg  [1:0]  O_REF_SEL,
	output reg         O_SAMPLE_CAP_SELECT_REDUCED,
	output reg  [4:0]  O_MUX_SEL,
	output reg         O_CONV_TICK,
	output reg         O_IRQ
);

	localparam [4:0] ST_IDLE   = 5'b00001;
	localparam [4:0] ST_INIT   = 5'b00010;
	localparam [4:0] ST_SAMPLE = 5'b00100;
	localparam [4:0] ST_CONV   = 5'b01000;
	localparam [4:0] ST_GAP    = 5'b10000;

	reg        enable_reg;
	reg  [7:0] clkref_reg;
	reg  [7:0] delay_reg;
	reg  [2:0] winmode_reg;
	reg  [4:0] sampling_extension_reg;
	reg  [4:0] insel_reg;
	reg  [1:0] irqmask_reg;
	reg  [1:0] irqstat_reg;
	reg [15:0] result_reg;
	reg [15:0] winlow_reg;
	reg [15:0] winhigh_reg;
	reg        start_reg;
	reg        init_pend_reg;
	reg  [4:0] state_reg;
	reg  [4:0] state_next;
	reg  [8:0] phase_reg;
	reg  [8:0] phase_next;
	reg  [7:0] div_reg;

	wire [5:0] idx = I_PADDR[7:2];
	wire       access = I_PSEL & I_PENABLE & ~O_PREADY;
	wire       done_xfer = I_PSEL & I_PENABLE & O_PREADY;
	wire       wr = done_xfer & I_PWRITE & ~O_PSLVERR;
	wire       rd = done_xfer & ~I_PWRITE & ~O_PSLVERR;

	// address check: aligned and one of the mapped indexes
	reg mapped;
	always @* begin
		case (idx)
		`ADCTWC_IDX_CTRL, `ADCTWC_IDX_CLKREF, `ADCTWC_IDX_DELAY,
		`ADCTWC_IDX_WINMODE, `ADCTWC_IDX_SAMPLING_EXTENSION, `ADCTWC_IDX_INSEL,
		`ADCTWC_IDX_COMMAND, `ADCTWC_IDX_IRQMASK, `ADCTWC_IDX_IRQSTAT,
		`ADCTWC_IDX_RESULT, `ADCTWC_IDX_WINLOW,
		`ADCTWC_IDX_WINHIGH: mapped = (I_PADDR[1:0] == 2'h0);
		default: mapped = 1'b0;
		endcase
	end

	// converter clock as a one-cycle enable from a free counter
	// no divided clock net, so every register stays on I_CLK
	wire [2:0] div_code = clkref_reg[`ADCTWC_CR_DIV_HI:0];
	wire [8:0] div_span = `ADCTWC_DIV_BASE << div_code;
	wire [8:0] div_mask = div_span - `ADCTWC_ONE;
	wire       tick = ((div_reg & div_mask[7:0]) == div_mask[7:0]);

	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			div_reg <= `ADCTWC_RST_BYTE;
			O_CONV_TICK <= 1'b0;
		end else begin
			div_reg <= div_reg + 8'h01;
			O_CONV_TICK <= tick;
		end
	end

	// start-up delay length, reserved codes take the longest
	reg [8:0] init_len;
	always @* begin
		case (delay_reg[`ADCTWC_DL_INIT_HI:`ADCTWC_DL_INIT_LO])
		3'h0: init_len = `ADCTWC_INIT_0;
		3'h1: init_len = `ADCTWC_INIT_16;
		3'h2: init_len = `ADCTWC_INIT_32;
		3'h3: init_len = `ADCTWC_INIT_64;
		3'h4: init_len = `ADCTWC_INIT_128;
		default: init_len = `ADCTWC_INIT_256;
		endcase
	end

	wire [8:0] samp_len = `ADCTWC_SAMPLE_BASE + {4'h0, sampling_extension_reg};
	wire [3:0] gap_code = delay_reg[`ADCTWC_DL_GAP_HI:0];
	wire [8:0] gap_len  = {5'h00, gap_code};
	// phases end on a tick, so the first count of a phase may be short
	wire       phase_end = tick & (phase_reg == `ADCTWC_ONE);
	wire       sample_done = (state_reg == ST_CONV) & I_CORE_DONE;
	wire       conv_end = sample_done & I_CORE_LAST;
	// armed by the 0 to 1 step, so rewriting a one does not re-arm
	wire       enable_rise = wr & (idx == `ADCTWC_IDX_CTRL) &
		I_PWDATA[`ADCTWC_CTRL_ENABLE] & ~enable_reg;
	wire [1:0] new_ref = I_PWDATA[`ADCTWC_CR_REF_HI:`ADCTWC_CR_REF_LO];
	wire [1:0] old_ref = clkref_reg[`ADCTWC_CR_REF_HI:`ADCTWC_CR_REF_LO];
	wire       ref_to_int = wr & (idx == `ADCTWC_IDX_CLKREF) &
		(new_ref == `ADCTWC_REF_INTERNAL) &
		(old_ref != `ADCTWC_REF_INTERNAL);
	wire       start_wr = wr & (idx == `ADCTWC_IDX_COMMAND) &
		I_PWDATA[`ADCTWC_CMD_START] & enable_reg;

	// sequencer
	always @* begin
		state_next = state_reg;
		phase_next = phase_reg;
		case (state_reg)
		ST_IDLE: begin
			if (start_reg) begin
				if (init_pend_reg && init_len != `ADCTWC_ZERO9) begin
					state_next = ST_INIT;
					phase_next = init_len;
				end else begin
					state_next = ST_SAMPLE;
					phase_next = samp_len;
				end
			end
		end
		ST_INIT: begin
			if (tick)
				phase_next = phase_reg - `ADCTWC_ONE;
			if (phase_end) begin
				state_next = ST_SAMPLE;
				phase_next = samp_len;
			end
		end
		ST_SAMPLE: begin
			if (tick)
				phase_next = phase_reg - `ADCTWC_ONE;
			if (phase_end)
				state_next = ST_CONV;
		end
		ST_CONV: begin
			if (conv_end) begin
				state_next = ST_IDLE;
			end else if (sample_done) begin
				if (gap_len == `ADCTWC_ZERO9) begin
					state_next = ST_SAMPLE;
					phase_next = samp_len;
				end else begin
					state_next = ST_GAP;
					phase_next = gap_len;
				end
			end
		end
		ST_GAP: begin
			if (tick)
				phase_next = phase_reg - `ADCTWC_ONE;
			if (phase_end) begin
				state_next = ST_SAMPLE;
				phase_next = samp_len;
			end
		end
		default: begin
			state_next = ST_IDLE;
			phase_next = `ADCTWC_ZERO9;
		end
		endcase
		// disable overrides every state and aborts a conversion
		if (!enable_reg) begin
			state_next = ST_IDLE;
			phase_next = `ADCTWC_ZERO9;
		end
	end

	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_reg <= ST_IDLE;
			phase_reg <= `ADCTWC_ZERO9;
			O_CORE_CONVERT <= 1'b0;
			O_SAMPLE_CLOSE <= 1'b0;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			O_CORE_CONVERT <= (state_next == ST_CONV);
			// switch closed only while sampling, open in gap
			O_SAMPLE_CLOSE <= (state_next == ST_SAMPLE);
		end
	end

	// window compare on the final accumulated result
	// inside and outside use strict compares at both thresholds
	reg win_hit;
	always @* begin
		case (winmode_reg)
		`ADCTWC_WIN_BELOW:  win_hit = (I_CORE_RESULT < winlow_reg);
		`ADCTWC_WIN_ABOVE:  win_hit = (I_CORE_RESULT > winhigh_reg);
		`ADCTWC_WIN_INSIDE: win_hit = (I_CORE_RESULT > winlow_reg) &
			(I_CORE_RESULT < winhigh_reg);
		`ADCTWC_WIN_OUTSIDE: win_hit = (I_CORE_RESULT < winlow_reg) |
			(I_CORE_RESULT > winhigh_reg);
		default: win_hit = 1'b0;
		endcase
	end

	// input select decode, reserved codes park on ground
	function [4:0] mux_map;
		input [4:0] code;
		begin
			if (code <= `ADCTWC_IN_PIN_LAST || code == `ADCTWC_IN_DACREF ||
				code == `ADCTWC_IN_TEMP)
				mux_map = code;
			else
				mux_map = `ADCTWC_IN_GROUND;
		end
	endfunction

	// reference decode, the reserved code takes the external pin
	wire [1:0] ref_eff = (old_ref == `ADCTWC_REF_RESERVED) ?
		`ADCTWC_REF_EXTERNAL : old_ref;

	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_REF_SEL <= `ADCTWC_REF_INTERNAL;
			O_SAMPLE_CAP_SELECT_REDUCED <= 1'b0;
			O_MUX_SEL <= `ADCTWC_RST_FIELD;
		end else begin
			O_REF_SEL <= ref_eff;
			O_SAMPLE_CAP_SELECT_REDUCED <= clkref_reg[`ADCTWC_CR_SAMPLE_CAP_SELECT];
			// held while busy so the core sees one input per conversion
			if (state_reg == ST_IDLE && state_next == ST_IDLE)
				O_MUX_SEL <= mux_map(insel_reg);
		end
	end

	// register file
	// reading the result clears both flags, like a write of ones
	wire clr_by_result = rd & (idx == `ADCTWC_IDX_RESULT);
	wire [1:0] stat_w1c = (wr && idx == `ADCTWC_IDX_IRQSTAT) ?
		I_PWDATA[`ADCTWC_IRQ_WINDOW:`ADCTWC_IRQ_READY] : `ADCTWC_RST_FLAGS;
	wire [1:0] stat_set = {conv_end & win_hit, conv_end};
	wire [1:0] stat_clr = stat_w1c | {2{clr_by_result}};
	wire [3:0] gap_inc = gap_code + 4'h1;

	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			enable_reg <= 1'b0;
			clkref_reg <= `ADCTWC_RST_BYTE;
			delay_reg <= `ADCTWC_RST_BYTE;
			winmode_reg <= `ADCTWC_RST_MODE;
			sampling_extension_reg <= `ADCTWC_RST_FIELD;
			insel_reg <= `ADCTWC_RST_FIELD;
			irqmask_reg <= `ADCTWC_RST_FLAGS;
			irqstat_reg <= `ADCTWC_RST_FLAGS;
			result_reg <= `ADCTWC_RST_WORD;
			winlow_reg <= `ADCTWC_RST_WORD;
			winhigh_reg <= `ADCTWC_RST_WORD;
			start_reg <= 1'b0;
			init_pend_reg <= 1'b0;
		end else begin
			if (wr) begin
				case (idx)
				`ADCTWC_IDX_CTRL: enable_reg <= I_PWDATA[`ADCTWC_CTRL_ENABLE];
				`ADCTWC_IDX_CLKREF: clkref_reg <= {1'b0,
					I_PWDATA[`ADCTWC_CR_SAMPLE_CAP_SELECT:`ADCTWC_CR_REF_LO],
					1'b0, I_PWDATA[`ADCTWC_CR_DIV_HI:0]};
				`ADCTWC_IDX_WINMODE: winmode_reg <= I_PWDATA[`ADCTWC_WM_HI:0];
				`ADCTWC_IDX_SAMPLING_EXTENSION: sampling_extension_reg <= I_PWDATA[`ADCTWC_SL_HI:0];
				`ADCTWC_IDX_INSEL: insel_reg <= I_PWDATA[`ADCTWC_IS_HI:0];
				`ADCTWC_IDX_IRQMASK: irqmask_reg <=
					I_PWDATA[`ADCTWC_IRQ_WINDOW:`ADCTWC_IRQ_READY];
				`ADCTWC_IDX_WINLOW: winlow_reg <= I_PWDATA[15:0];
				`ADCTWC_IDX_WINHIGH: winhigh_reg <= I_PWDATA[15:0];
				default: ;
				endcase
			end
			// a software write of the delay register wins over the step
			if (wr && idx == `ADCTWC_IDX_DELAY)
				delay_reg <= I_PWDATA[7:0];
			else if (sample_done && delay_reg[`ADCTWC_DL_AUTOVAR])
				delay_reg <= {delay_reg[7:4], gap_inc};
			if (conv_end)
				result_reg <= I_CORE_RESULT;
			// set beats clear in the same cycle
			irqstat_reg <= (irqstat_reg & ~stat_clr) | stat_set;
			// the bit reads one until the whole conversion ends
			if (conv_end || !enable_reg)
				start_reg <= 1'b0;
			else if (start_wr)
				start_reg <= 1'b1;
			// any start consumes the pending delay, code zero too, so a
			// later code change cannot stall an unrelated conversion
			if (enable_rise || ref_to_int || I_DEEP_WAKE)
				init_pend_reg <= 1'b1;
			else if (state_reg == ST_IDLE && state_next != ST_IDLE)
				init_pend_reg <= 1'b0;
		end
	end

	// read mux, reserved bits read as zero
	reg [31:0] rdata;
	always @* begin
		rdata = 32'h0000_0000;
		case (idx)
		`ADCTWC_IDX_CTRL:    rdata[0] = enable_reg;
		`ADCTWC_IDX_CLKREF:  rdata[7:0] = clkref_reg;
		`ADCTWC_IDX_DELAY:   rdata[7:0] = delay_reg;
		`ADCTWC_IDX_WINMODE: rdata[2:0] = winmode_reg;
		`ADCTWC_IDX_SAMPLING_EXTENSION: rdata[4:0] = sampling_extension_reg;
		`ADCTWC_IDX_INSEL:   rdata[4:0] = insel_reg;
		`ADCTWC_IDX_COMMAND: rdata[0] = start_reg;
		`ADCTWC_IDX_IRQMASK: rdata[1:0] = irqmask_reg;
		`ADCTWC_IDX_IRQSTAT: rdata[1:0] = irqstat_reg;
		`ADCTWC_IDX_RESULT:  rdata[15:0] = result_reg;
		`ADCTWC_IDX_WINLOW:  rdata[15:0] = winlow_reg;
		`ADCTWC_IDX_WINHIGH: rdata[15:0] = winhigh_reg;
		default:             rdata = 32'h0000_0000;
		endcase
	end

	// apb: one wait state, answer in the second access cycle
	always @(posedge I_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA <= 32'h0000_0000;
			O_IRQ <= 1'b0;
		end else begin
			O_PREADY <= access;
			O_PSLVERR <= access & ~mapped;
			if (access && !I_PWRITE && mapped)
				O_PRDATA <= rdata;
			else if (access)
				O_PRDATA <= 32'h0000_0000;
			O_IRQ <= |(((irqstat_reg & ~stat_clr) | stat_set) & irqmask_reg);
		end
	end

endmodule

`default_nettype wire

/* verif/adctwc_core_model.sv */
// analog core stand-in: answers each convert level with a done pulse
// assumes: convert held until done is seen, one clock domain
`timescale 1ns/100ps
`default_nettype none
module adctwc_core_model (
	input  wire logic        i_clk,
	input  wire logic        i_convert,
	input  wire logic [1:0]  i_nsmp,
	input  wire logic [15:0] i_res,
	output var  logic        o_done,
	output wire logic        o_last,
	output wire logic [15:0] o_result
);
	logic [1:0] cnt = 2'h0;
	logic [1:0] smp = 2'h0;
	initial o_done = 1'h0;
	always @(posedge i_clk) begin
		o_done <= 1'h0;
		if (i_convert && !o_done)
			cnt <= cnt + 2'h1;
		if (cnt == 2'h3) begin
			cnt <= 2'h0;
			o_done <= 1'h1;
			smp <= (smp + 2'h1 == i_nsmp) ? 2'h0 : smp + 2'h1;
		end
	end
	assign o_last = o_done && smp == 2'h0;
	// result is junk outside the done cycle
	assign o_result = o_done ? i_res : ~i_res;
endmodule
`default_nettype wire

/* verif/adctwc_top_assertions.sv */
// port assertions of the converter timing and window control block
// assumes: bound into adctwc_top, one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module adctwc_top_assertions (
	input wire logic       I_CLK,
	input wire logic       I_ARST_N,
	input wire logic       O_PREADY,
	input wire logic       O_PSLVERR,
	input wire logic       I_CORE_DONE,
	input wire logic       I_CORE_LAST,
	input wire logic       O_CORE_CONVERT,
	input wire logic       O_SAMPLE_CLOSE,
	input wire logic [1:0] O_REF_SEL,
	input wire logic [4:0] O_MUX_SEL,
	input wire logic       O_CONV_TICK
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_ARST_N);
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
		else $error("error without ready");
	a_tick_single: assert property (O_CONV_TICK |=> !O_CONV_TICK)
		else $error("tick longer than one cycle");
	a_close_open: assert property (
		O_SAMPLE_CLOSE |-> !O_CORE_CONVERT) else $error("switch shut late");
	a_conv_end: assert property (
		O_CORE_CONVERT && I_CORE_DONE && I_CORE_LAST |=> !O_CORE_CONVERT)
		else $error("conversion not ended");
	a_mux_frozen: assert property (
		O_CORE_CONVERT |=> $stable(O_MUX_SEL)) else $error("mux moved");
	a_ref_legal: assert property (O_REF_SEL != 2'h3)
		else $error("reserved reference driven");
	a_mux_legal: assert property (O_MUX_SEL < 5'h10 ||
		O_MUX_SEL == 5'h1c || O_MUX_SEL >= 5'h1e) else $error("bad mux");
	a_sample_min: assert property (
		$rose(O_SAMPLE_CLOSE) |-> O_SAMPLE_CLOSE [*3])
		else $error("sampling too short");
endmodule
bind adctwc_top adctwc_top_assertions u_chk (.I_CLK, .I_ARST_N,
	.O_PREADY, .O_PSLVERR, .I_CORE_DONE, .I_CORE_LAST, .O_CORE_CONVERT,
	.O_SAMPLE_CLOSE, .O_REF_SEL, .O_MUX_SEL, .O_CONV_TICK);
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench of the converter timing and window control block
// assumes: core stand-in on the analog side, APB master in here
`include "adctwc_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        psel = 1'h0;
	logic        pen = 1'h0;
	logic        pwr = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        wake = 1'h0;
	logic [1:0]  nsmp = 2'h1;
	logic [15:0] res = 16'h0;
	logic [31:0] prdata;
	logic [15:0] cres;
	logic [4:0]  mux;
	logic [1:0]  reference_choice;
	logic        pready, perr, done, last, busy, close, cap, tick, irq;
	logic        fin;
	int          n_fail = 0;
	int          compares = 0;
	assign fin = done & last;
	adctwc_top DUT (.I_CLK(clk), .I_ARST_N(rst_n), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
		.I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(perr), .I_DEEP_WAKE(wake), .I_CORE_DONE(done),
		.I_CORE_LAST(last), .I_CORE_RESULT(cres), .O_CORE_CONVERT(busy),
		.O_SAMPLE_CLOSE(close), .O_REF_SEL(reference_choice),
		.O_SAMPLE_CAP_SELECT_REDUCED(cap), .O_MUX_SEL(mux), .O_CONV_TICK(tick),
		.O_IRQ(irq));
	adctwc_core_model core (.i_clk(clk), .i_convert(busy), .i_nsmp(nsmp),
		.i_res(res), .o_done(done), .o_last(last), .o_result(cres));
	initial forever #2 clk = ~clk;
	task automatic chk(input string s, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic bail;
		n_fail++;
		$display("wrong value wait expected end seen none");
		finish_test();
	endtask
	task automatic apb(input logic [5:0] i, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		psel <= 1'h1;
		pwr <= w;
		paddr <= {i, 2'h0};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 99);
		if (n >= 99)
			bail();
		r = prdata;
		if (!w && i == 6'h07)
			r = {31'h0, perr};
		psel <= 1'h0;
		pen <= 1'h0;
		// idle edge so the next setup never lands in this time step
		@(posedge clk);
	endtask
	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		logic [31:0] r;
		apb(i, 1'h1, d, r);
	endtask
	task automatic rd(input logic [5:0] i, output logic [31:0] r);
		apb(i, 1'h0, 32'h0, r);
	endtask
	task automatic hold(input int s, input logic v, output int n);
		n = 0;
		while ((s ? fin : close) === v && n < 999) begin
			@(posedge clk);
			n++;
		end
		if (n >= 999)
			bail();
	endtask
	task automatic start(output int ts);
		int n;
		wr(`ADCTWC_IDX_COMMAND, 32'h1);
		hold(0, 1'h0, ts);
		hold(1, 1'h0, n);
		@(posedge clk);
	endtask
	task automatic tk(output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (tick !== 1'h1 && n < 600);
	endtask
	function automatic logic win(int m, logic [15:0] r);
		case (m)
		1: return r < 16'h0100;
		2: return r > 16'h8000;
		3: return r > 16'h0100 && r < 16'h8000;
		4: return r < 16'h0100 || r > 16'h8000;
		default: return 1'h0;
		endcase
	endfunction
	task automatic t_regs;
		logic [31:0] r;
		for (int i = 3; i < 9; i++) begin
			rd(i[5:0], r);
			chk("reset or slverr", i == 7, r);
		end
		wr(`ADCTWC_IDX_SAMPLING_EXTENSION, 32'hffffffff);
		rd(`ADCTWC_IDX_SAMPLING_EXTENSION, r);
		chk("sampling_extension", 32'h1f, r);
		wr(`ADCTWC_IDX_RESULT, 32'h5a5a);
		rd(`ADCTWC_IDX_RESULT, r);
		chk("result ro", 32'h0, r);
	endtask
	task automatic t_clk;
		int n;
		for (int c = 0; c < 8; c++) begin
			wr(`ADCTWC_IDX_CLKREF, c);
			tk(n);
			tk(n);
			chk("tick period", 32'h2 << c, n);
		end
		for (int c = 0; c < 4; c++) begin
			wr(`ADCTWC_IDX_CLKREF, c * 16 + c % 2 * 64);
			@(posedge clk);
			n = {c[0], c == 3 ? 2'h2 : c[1:0]};
			chk("ref cap", n, {cap, reference_choice});
		end
		wr(`ADCTWC_IDX_CLKREF, 32'h10);
	endtask
	task automatic t_conv;
		logic [31:0] r;
		int n;
		wr(`ADCTWC_IDX_CTRL, 32'h1);
		wr(`ADCTWC_IDX_SAMPLING_EXTENSION, 32'h3);
		res <= 16'h1234;
		wr(`ADCTWC_IDX_COMMAND, 32'h1);
		hold(0, 1'h0, n);
		hold(0, 1'h1, n);
		chk("sample len", 1, n >= 9 && n <= 10);
		rd(`ADCTWC_IDX_COMMAND, r);
		chk("start busy", 32'h1, r);
		hold(1, 1'h0, n);
		@(posedge clk);
		rd(`ADCTWC_IDX_COMMAND, r);
		chk("start clear", 32'h0, r);
		rd(`ADCTWC_IDX_IRQSTAT, r);
		chk("ready flag", 32'h1, r);
		chk("irq masked", 1'h0, irq);
		wr(`ADCTWC_IDX_IRQMASK, 32'h1);
		@(posedge clk);
		chk("irq on", 1'h1, irq);
		wr(`ADCTWC_IDX_IRQSTAT, 32'h1);
		@(posedge clk);
		chk("irq off", 1'h0, irq);
		rd(`ADCTWC_IDX_RESULT, r);
		chk("result", 32'h1234, r);
	endtask
	task automatic t_init;
		int n;
		for (int c = 1; c < 7; c++) begin
			wr(`ADCTWC_IDX_DELAY, c * 32);
			if (c % 3 == 0) begin
				wake <= 1'h1;
				@(posedge clk);
				wake <= 1'h0;
			end else if (c % 3 == 1) begin
				wr(`ADCTWC_IDX_CTRL, 32'h0);
				wr(`ADCTWC_IDX_CTRL, 32'h1);
			end else begin
				wr(`ADCTWC_IDX_CLKREF, 32'h10);
				wr(`ADCTWC_IDX_CLKREF, 32'h00);
			end
			start(n);
			n -= 32 << (c > 5 ? 4 : c - 1);
			chk("init delay", 1, n >= -2 && n <= 4);
		end
		start(n);
		chk("no delay", 1, n <= 4);
	endtask
	task automatic t_gap;
		logic [31:0] r;
		int n;
		nsmp <= 2'h2;
		wr(`ADCTWC_IDX_DELAY, 32'h08);
		wr(`ADCTWC_IDX_COMMAND, 32'h1);
		hold(0, 1'h0, n);
		hold(0, 1'h1, n);
		hold(0, 1'h0, n);
		chk("gap len", 1, n >= 19 && n <= 24);
		hold(1, 1'h0, n);
		@(posedge clk);
		wr(`ADCTWC_IDX_DELAY, 32'h1e);
		start(n);
		rd(`ADCTWC_IDX_DELAY, r);
		chk("gap wrap", 32'h10, r);
		nsmp <= 2'h1;
	endtask
	task automatic t_win;
		logic [31:0] r;
		logic [15:0] v[5] = '{16'h00ff, 16'h0100, 16'h4000, 16'h8000,
			16'h8001};
		int n;
		wr(`ADCTWC_IDX_WINLOW, 32'h0100);
		wr(`ADCTWC_IDX_WINHIGH, 32'h8000);
		for (int m = 0; m < 6; m++) begin
			wr(`ADCTWC_IDX_WINMODE, m);
			for (int k = 0; k < 5; k++) begin
				res <= v[k];
				start(n);
				rd(`ADCTWC_IDX_IRQSTAT, r);
				chk("flags", {win(m, v[k]), 1'h1}, r);
				rd(`ADCTWC_IDX_RESULT, r);
				chk("result", v[k], r);
			end
		end
	endtask
	task automatic t_mux;
		int n;
		for (int c = 0; c < 32; c++) begin
			wr(`ADCTWC_IDX_INSEL, c);
			@(posedge clk);
			n = (c < 16 || c == 28 || c == 30) ? c : 31;
			chk("mux", n, mux);
		end
		wr(`ADCTWC_IDX_INSEL, 32'h5);
		wr(`ADCTWC_IDX_COMMAND, 32'h1);
		wr(`ADCTWC_IDX_INSEL, 32'h1c);
		chk("mux held", 5'h05, mux);
		hold(1, 1'h0, n);
		repeat (2) @(posedge clk);
		chk("mux later", 5'h1c, mux);
	endtask
	initial begin
		#400000;
		bail();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_regs();
		$display("registers test ended");
		t_clk();
		$display("clock and reference test ended");
		t_conv();
		$display("conversion test ended");
		t_init();
		$display("start-up delay test ended");
		t_gap();
		$display("sample gap test ended");
		t_win();
		$display("window test ended");
		t_mux();
		$display("input select test ended");
		finish_test();
	end
endmodule
`default_nettype wire
